// [core/tcc_pkg.sv]
// package: register map, reset values and carriers for the timer capture/compare block
package tcc_pkg;

   // io offsets (short io space) and data-space displacement
   localparam logic [7:0] IO_TO_DATA_OFFSET  = 8'h20;
   localparam logic [7:0] SHORT_IO_LIMIT     = 8'h3f;
   localparam logic [7:0] EXT_IO_BASE        = 8'h60;

   localparam logic [7:0] CAPTURE1_LOW_OFS   = 8'h26;
   localparam logic [7:0] CAPTURE1_HIGH_OFS  = 8'h27;
   localparam logic [7:0] CAPTURE3_LOW_OFS   = 8'h80;
   localparam logic [7:0] CAPTURE3_HIGH_OFS  = 8'h81;
   localparam logic [7:0] COMPARE3C_LOW_OFS  = 8'h82;
   localparam logic [7:0] COMPARE3C_HIGH_OFS = 8'h83;
   localparam logic [7:0] COMPARE3B_LOW_OFS  = 8'h84;
   localparam logic [7:0] COMPARE3B_HIGH_OFS = 8'h85;
   localparam logic [7:0] COMPARE3A_LOW_OFS  = 8'h86;
   localparam logic [7:0] COMPARE3A_HIGH_OFS = 8'h87;

   localparam logic [7:0]  BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;

   // cpu byte access to the register space
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       data_space;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tcc_bus_s;

   // per-timer counter side inputs
   typedef struct packed {
      logic [15:0] running_count;
      logic        capture_input_pin;
   } tcc_timer_in_s;

endpackage : tcc_pkg

// [core/tcc_capture_unit.sv]
// one timer's capture register with edge detect, edge polarity select and flag
`timescale 1ns/1ns
module tcc_capture_unit
   import tcc_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             trig_i,
   input  wire logic             rising_i,
   input  wire logic [WIDTH-1:0] count_i,
   input  wire logic             wr_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   input  wire logic             flag_clr_i,
   output logic      [WIDTH-1:0] value_o,
   output logic                  flag_o,
   output logic                  event_o
);

   logic             trig_d;
   logic             next_trig_d;
   logic [WIDTH-1:0] next_value;
   logic             next_flag;
   logic             hit;

   always_comb begin
      next_trig_d = trig_i;
      hit         = rising_i ? (trig_i & ~trig_d) : (~trig_i & trig_d);
      next_value  = value_o;
      if (wr_i) begin
         next_value = wdata_i;
      end
      if (hit) begin
         next_value = count_i;
      end
      // a clear in the same cycle as an event loses, so no event is dropped
      next_flag = flag_o;
      if (flag_clr_i) begin
         next_flag = 1'b0;
      end
      if (hit) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trig_d  <= 1'b0;
         value_o <= '0;
         flag_o  <= 1'b0;
      end else begin
         trig_d  <= next_trig_d;
         value_o <= next_value;
         flag_o  <= next_flag;
      end
   end

   assign event_o = hit;

endmodule : tcc_capture_unit

// [core/tcc_regs.sv]
// capture and compare register file of the two 16-bit timers
//
// Behaviour
// - capture event copies running count into capture
// - first timer may trigger from analog comparator
// - capture value may serve as counter top
// - capture is 16 bits, low/high byte locations
// - byte accesses go through 8-bit high latch, except compare reads
// - one latch shared by all 16-bit registers
// - data address equals io offset plus 0x20 for short io space only
// - third timer registers at 0x80..0x87, low even
// - capture sets flag; write-one or vector clears
// - match flag set two cycles after compare match
`timescale 1ns/1ns
module tcc_regs
   import tcc_pkg::*;
(
   input  wire logic          mclk_i,
   input  wire logic          rstn_i,
   input  wire tcc_bus_s      bus_i,
   output logic        [7:0]  rdata_o,
   output logic               hit_o,
   input  wire tcc_timer_in_s timer1_i,
   input  wire tcc_timer_in_s timer3_i,
   input  wire logic          comparator_out_i,
   input  wire logic          timer1_use_comparator_i,
   input  wire logic          timer1_rising_i,
   input  wire logic          timer3_rising_i,
   input  wire logic          timer1_capture_is_top_i,
   input  wire logic          timer3_capture_is_top_i,
   input  wire logic          timer1_capture_flag_clr_i,
   input  wire logic          timer3_capture_flag_clr_i,
   input  wire logic   [2:0]  timer3_match_flag_clr_i,
   output logic        [15:0] first_timer_capture_value_o,
   output logic        [15:0] third_timer_capture_value_o,
   output logic        [15:0] third_timer_compare_a_o,
   output logic        [15:0] third_timer_compare_b_o,
   output logic        [15:0] third_timer_compare_c_o,
   output logic        [15:0] timer1_top_o,
   output logic        [15:0] timer3_top_o,
   output logic               first_timer_capture_flag_o,
   output logic               third_timer_capture_flag_o,
   output logic        [2:0]  third_timer_match_flag_o
);

   ////////////////////////////////////////////////////////////////////////
   // reset release and address decode

   logic       rst_meta;
   logic       rst_n;
   logic [7:0] io_addr;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // short io space is addressed by io offset; data space sees low io
   // space shifted by 0x20 and the extended area at its own address
   always_comb begin
      io_addr = bus_i.addr;
      if (bus_i.data_space && bus_i.addr < EXT_IO_BASE) begin
         io_addr = bus_i.addr - IO_TO_DATA_OFFSET;
      end
   end

   logic acc_ok;
   // extended registers answer only through data-space access
   assign acc_ok = bus_i.data_space ? (bus_i.addr >= IO_TO_DATA_OFFSET)
                                    : (bus_i.addr <= SHORT_IO_LIMIT);

   logic sel_c1l, sel_c1h, sel_c3l, sel_c3h;
   logic [2:0] sel_ml;
   logic [2:0] sel_mh;

   always_comb begin
      sel_c1l = acc_ok && io_addr == CAPTURE1_LOW_OFS;
      sel_c1h = acc_ok && io_addr == CAPTURE1_HIGH_OFS;
      sel_c3l = acc_ok && io_addr == CAPTURE3_LOW_OFS;
      sel_c3h = acc_ok && io_addr == CAPTURE3_HIGH_OFS;
      sel_ml  = {acc_ok && io_addr == COMPARE3C_LOW_OFS,
                 acc_ok && io_addr == COMPARE3B_LOW_OFS,
                 acc_ok && io_addr == COMPARE3A_LOW_OFS};
      sel_mh  = {acc_ok && io_addr == COMPARE3C_HIGH_OFS,
                 acc_ok && io_addr == COMPARE3B_HIGH_OFS,
                 acc_ok && io_addr == COMPARE3A_HIGH_OFS};
   end

   assign hit_o = sel_c1l | sel_c1h | sel_c3l | sel_c3h | (|sel_ml) | (|sel_mh);

   ////////////////////////////////////////////////////////////////////////
   // shared high-byte latch

   logic [7:0] temp_high;
   logic [7:0] next_temp_high;
   logic [15:0] cmp [3];

   // one latch for every 16-bit register, so interleaving two 16-bit
   // accesses (e.g. from an interrupt) corrupts the pair; software masks
   always_comb begin
      next_temp_high = temp_high;
      if (bus_i.wr && hit_o && (sel_c1h | sel_c3h | (|sel_mh))) begin
         next_temp_high = bus_i.wdata;
      end else if (bus_i.rd && sel_c1l) begin
         next_temp_high = first_timer_capture_value_o[15:8];
      end else if (bus_i.rd && sel_c3l) begin
         next_temp_high = third_timer_capture_value_o[15:8];
      end else if (bus_i.rd && (|sel_ml)) begin
         // compare registers are written only as pairs, so high reads direct
         next_temp_high = temp_high;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         temp_high <= BYTE_RESET;
      end else begin
         temp_high <= next_temp_high;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // capture units

   logic wr_c1, wr_c3;
   logic [15:0] pair_word;

   assign wr_c1     = bus_i.wr && sel_c1l;
   assign wr_c3     = bus_i.wr && sel_c3l;
   assign pair_word = {temp_high, bus_i.wdata};

   tcc_capture_unit #(.WIDTH(16)) u_cap1 (
      .clk_i      (mclk_i),
      .rst_n_i    (rst_n),
      .trig_i     (timer1_use_comparator_i ? comparator_out_i
                                           : timer1_i.capture_input_pin),
      .rising_i   (timer1_rising_i),
      .count_i    (timer1_i.running_count),
      .wr_i       (wr_c1),
      .wdata_i    (pair_word),
      .flag_clr_i (timer1_capture_flag_clr_i),
      .value_o    (first_timer_capture_value_o),
      .flag_o     (first_timer_capture_flag_o),
      .event_o    ()
   );

   tcc_capture_unit #(.WIDTH(16)) u_cap3 (
      .clk_i      (mclk_i),
      .rst_n_i    (rst_n),
      .trig_i     (timer3_i.capture_input_pin),
      .rising_i   (timer3_rising_i),
      .count_i    (timer3_i.running_count),
      .wr_i       (wr_c3),
      .wdata_i    (pair_word),
      .flag_clr_i (timer3_capture_flag_clr_i),
      .value_o    (third_timer_capture_value_o),
      .flag_o     (third_timer_capture_flag_o),
      .event_o    ()
   );

   // capture register doubles as top when the counting mode asks for it
   assign timer1_top_o = timer1_capture_is_top_i ? first_timer_capture_value_o
                                                 : 16'hffff;
   assign timer3_top_o = timer3_capture_is_top_i ? third_timer_capture_value_o
                                                 : 16'hffff;

   ////////////////////////////////////////////////////////////////////////
   // third timer compare registers and match flags

   logic [15:0] next_cmp [3];
   logic [2:0]  match_d;
   logic [2:0]  next_match_d;
   logic [2:0]  next_flag;

   for (genvar g = 0; g < 3; g++) begin : g_cmp
      always_comb begin
         next_cmp[g] = cmp[g];
         if (bus_i.wr && sel_ml[g]) begin
            next_cmp[g] = pair_word;
         end
         next_match_d[g] = (timer3_i.running_count == cmp[g]);
         // flag rises two cycles after the match (match_d stage); a set beats a clear
         next_flag[g] = third_timer_match_flag_o[g];
         if (timer3_match_flag_clr_i[g]) begin
            next_flag[g] = 1'b0;
         end
         if (match_d[g]) begin
            next_flag[g] = 1'b1;
         end
      end

      always_ff @(posedge mclk_i or negedge rst_n) begin
         if (!rst_n) begin
            cmp[g]                      <= WORD_RESET;
            match_d[g]                  <= 1'b0;
            third_timer_match_flag_o[g] <= 1'b0;
         end else begin
            cmp[g]                      <= next_cmp[g];
            match_d[g]                  <= next_match_d[g];
            third_timer_match_flag_o[g] <= next_flag[g];
         end
      end
   end

   assign third_timer_compare_a_o = cmp[0];
   assign third_timer_compare_b_o = cmp[1];
   assign third_timer_compare_c_o = cmp[2];

   ////////////////////////////////////////////////////////////////////////
   // read data, registered for one cycle

   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      if (bus_i.rd) begin
         if (sel_c1l) next_rdata = first_timer_capture_value_o[7:0];
         if (sel_c1h) next_rdata = temp_high;
         if (sel_c3l) next_rdata = third_timer_capture_value_o[7:0];
         if (sel_c3h) next_rdata = temp_high;
         for (int i = 0; i < 3; i++) begin
            if (sel_ml[i]) next_rdata = cmp[i][7:0];
            if (sel_mh[i]) next_rdata = cmp[i][15:8];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         rdata_o <= BYTE_RESET;
      end else begin
         rdata_o <= next_rdata;
      end
   end

endmodule : tcc_regs

// [bench/tcc_src.sv]
// far-side model: capture pins and comparator output
`timescale 1ns/1ns
module tcc_src (
   input  wire logic mclk_i,
   input  wire logic tg1_i,
   input  wire logic tg3_i,
   input  wire logic tgc_i,
   output logic      pin1_o,
   output logic      pin3_o,
   output logic      comp_o
);
   initial {pin1_o, pin3_o, comp_o} = '0;
   // levels move just after the edge so no sample sees a changing pin
   always @(posedge mclk_i) begin
      if (tg1_i) pin1_o <= #1 ~pin1_o;
      if (tg3_i) pin3_o <= #1 ~pin3_o;
      if (tgc_i) comp_o <= #1 ~comp_o;
   end
endmodule : tcc_src

// [bench/tcc_regs_sva.sv]
// checker: port-level assertions of the capture/compare register block
`timescale 1ns/1ns
module tcc_regs_sva
   import tcc_pkg::*;
(
   input wire logic          mclk_i,
   input wire logic          rstn_i,
   input wire tcc_bus_s      bus_i,
   input wire logic [7:0]    rdata_o,
   input wire logic          hit_o,
   input wire tcc_timer_in_s timer3_i,
   input wire logic          timer3_rising_i,
   input wire logic          timer1_capture_is_top_i,
   input wire logic          timer3_capture_flag_clr_i,
   input wire logic [15:0]   first_timer_capture_value_o,
   input wire logic [15:0]   third_timer_capture_value_o,
   input wire logic [15:0]   third_timer_compare_b_o,
   input wire logic [15:0]   timer1_top_o,
   input wire logic          third_timer_capture_flag_o,
   input wire logic [2:0]    third_timer_match_flag_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////////////////////////////
   // internal reset trails the pin by two edges, so events wait
   logic [1:0] up;
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) up <= 2'd0;
      else if (up != 2'd3) up <= up + 2'd1;
   end
   sequence s_lo_rd; bus_i.rd && bus_i.data_space && bus_i.addr == 8'h80; endsequence
   sequence s_hi_rd; bus_i.rd && bus_i.data_space && bus_i.addr == 8'h81; endsequence
   sequence s_hi_wr; bus_i.wr && bus_i.data_space && bus_i.addr == 8'h85; endsequence
   sequence s_lo_wr; bus_i.wr && bus_i.data_space && bus_i.addr == 8'h84; endsequence
   ////////////////////////////////////////////////////////////////
   property p_idle_rd; !$past(bus_i.rd) |-> rdata_o == 8'h00; endproperty
   a_idle_rd: assert property (p_idle_rd) else $error("read data not idle");
   property p_refuse;
      (!bus_i.data_space && bus_i.addr > 8'h3f) || (bus_i.data_space && bus_i.addr < 8'h20)
      |-> !hit_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad address decoded");
   property p_ext; bus_i.data_space && bus_i.addr inside {[8'h80:8'h87]} |-> hit_o; endproperty
   a_ext: assert property (p_ext) else $error("extended register missed");
   property p_latch; s_lo_rd ##1 s_hi_rd |=>
      rdata_o == $past(third_timer_capture_value_o[15:8], 2); endproperty
   a_latch: assert property (p_latch) else $error("high byte not from latch");
   property p_pair; s_hi_wr ##1 s_lo_wr |=>
      third_timer_compare_b_o == {$past(bus_i.wdata, 2), $past(bus_i.wdata)}; endproperty
   a_pair: assert property (p_pair) else $error("word write not atomic");
   property p_cap;
      up == 2'd3 && $rose(timer3_i.capture_input_pin) && timer3_rising_i |-> ##[1:3]
      (third_timer_capture_value_o == timer3_i.running_count && third_timer_capture_flag_o);
   endproperty
   a_cap: assert property (p_cap) else $error("capture missed");
   property p_match; up == 2'd3 && timer3_i.running_count == third_timer_compare_b_o
      |-> ##[1:2] third_timer_match_flag_o[1]; endproperty
   a_match: assert property (p_match) else $error("match flag late");
   property p_top; timer1_top_o ==
      (timer1_capture_is_top_i ? first_timer_capture_value_o : 16'hffff); endproperty
   a_top: assert property (p_top) else $error("top value wrong");
   property p_clr; $fell(third_timer_capture_flag_o) |-> $past(timer3_capture_flag_clr_i);
   endproperty
   a_clr: assert property (p_clr) else $error("flag dropped unasked");
endmodule : tcc_regs_sva

// [bench/testbench.sv]
// self-checking bench of the capture/compare register block
`timescale 1ns/1ns
module testbench;
   import tcc_pkg::*;
   logic          mclk_i = 0, rstn_i = 0;
   tcc_bus_s      bus = '0;
   tcc_timer_in_s t1, t3;
   logic [15:0]   c1 = 0, c3 = 0, v1, v3, ca, cb, cc, tp1, tp3, w, x1, x3, vv [5];
   logic [7:0]    ad [5] = '{8'h26, 8'h80, 8'h82, 8'h84, 8'h86};
   logic [7:0]    rb, rdata;
   logic [2:0]    mclr = 0, mf;
   logic          hit, hb, ucmp = 0, r1 = 0, r3 = 0, top1 = 0, top3 = 0, clr1 = 0, clr3 = 0;
   logic          g1 = 0, g3 = 0, gc = 0, pu = 0, p1, p3, cmp, f1, f3, h1, h3;
   logic [31:0]   lf = 32'h6879;
   int            error_cnt = 0, tests_run = 0;
   assign t1 = {c1, p1};
   assign t3 = {c3, p3};
   tcc_src src (.mclk_i, .tg1_i(g1), .tg3_i(g3), .tgc_i(gc), .pin1_o(p1), .pin3_o(p3),
      .comp_o(cmp));
   tcc_regs uut (.mclk_i, .rstn_i, .bus_i(bus), .rdata_o(rdata), .hit_o(hit), .timer1_i(t1),
      .timer3_i(t3), .comparator_out_i(cmp), .timer1_use_comparator_i(ucmp),
      .timer1_rising_i(r1), .timer3_rising_i(r3), .timer1_capture_is_top_i(top1),
      .timer3_capture_is_top_i(top3), .timer1_capture_flag_clr_i(clr1),
      .timer3_capture_flag_clr_i(clr3), .timer3_match_flag_clr_i(mclr),
      .first_timer_capture_value_o(v1), .third_timer_capture_value_o(v3),
      .third_timer_compare_a_o(ca), .third_timer_compare_b_o(cb), .third_timer_compare_c_o(cc),
      .timer1_top_o(tp1), .timer3_top_o(tp3), .first_timer_capture_flag_o(f1),
      .third_timer_capture_flag_o(f3), .third_timer_match_flag_o(mf));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nx
   function automatic logic [7:0] dadr(input logic [7:0] a);
      return a[7] ? a : a + 8'h20;
   endfunction : dadr
   function automatic logic hitf(input logic tg, old, r);
      return tg && (!old == r);
   endfunction : hitf
   task automatic chk(input string n, input logic [15:0] e, g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // request held until the next edge; answer and decode taken just after it
   task automatic acc(input logic r, wr, ds, input logic [7:0] a, d);
      bus = '{r, wr, ds, a, d};
      @(posedge mclk_i);
      #1;
      rb = rdata;
      hb = hit;
   endtask : acc
   task automatic idle(input int n);
      bus = '0;
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : idle
   task automatic wr16(input logic ds, input logic [7:0] a, input logic [15:0] v);
      acc(0, 1, ds, a + 8'h1, v[15:8]);
      acc(0, 1, ds, a, v[7:0]);
      idle(1);
   endtask : wr16
   task automatic rd16(input logic [7:0] a, output logic [15:0] v);
      acc(1, 0, 1, a, 8'h00);
      v[7:0] = rb;
      acc(1, 0, 1, a + 8'h1, 8'h00);
      v[15:8] = rb;
      idle(1);
   endtask : rd16
   task automatic end_of_test;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   ////////////////////////////////////////////////////////////////
   initial forever #20 mclk_i = ~mclk_i;
   initial begin
      repeat (5000) @(posedge mclk_i);
      error_cnt++;
      end_of_test;
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      #1 rstn_i = 1;
      idle(3);
      foreach (ad[i]) begin
         rd16(dadr(ad[i]), w);
         chk("reset value", 16'h0000, w);
         lf = nx(lf);
         vv[i] = lf[15:0];
         wr16(ad[i][7], ad[i], vv[i]);
         rd16(dadr(ad[i]), w);
         chk("read back", vv[i], w);
      end
      chk("capture1", vv[0], v1);
      chk("capture3", vv[1], v3);
      chk("compare3c", vv[2], cc);
      chk("compare3b", vv[3], cb);
      acc(0, 1, 0, 8'h86, 8'hff);
      chk("hit", 0, hb);
      acc(0, 1, 1, 8'h06, 8'hff);
      chk("hit", 0, hb);
      acc(1, 0, 0, 8'h40, 8'h00);
      chk("refused read", 0, rb);
      idle(1);
      chk("compare3a", vv[4], ca);
      // low read of the first timer fills the one latch the third timer reads
      acc(1, 0, 1, 8'h46, 8'h00);
      acc(1, 0, 1, 8'h81, 8'h00);
      chk("shared latch", vv[0][15:8], rb);
      wr16(1, 8'h82, 16'h5aa5);
      chk("compare3c", 16'h5aa5, cc);
      x1 = vv[0];
      x3 = vv[1];
      for (int k = 0; k < 16; k++) begin
         lf = nx(lf);
         {c1, c3} = lf;
         {top1, top3, ucmp, r1, r3, g1, gc} = lf[6:0];
         g3 = 1;
         // a source switch between unequal levels is an edge of its own
         h1 = (ucmp ? hitf(gc, cmp, r1) : hitf(g1, p1, r1))
              || (pu != ucmp && cmp != p1 && (ucmp ? cmp : p1) == r1);
         h3 = hitf(1, p3, r3);
         pu = ucmp;
         if (h1) x1 = c1;
         if (h3) x3 = c3;
         idle(1);
         {g1, g3, gc} = 0;
         idle(4);
         chk("capture1", x1, v1);
         chk("capture3", x3, v3);
         chk("flags set", {h1, h3}, {f1, f3});
         chk("top1", top1 ? x1 : 16'hffff, tp1);
         chk("top3", top3 ? x3 : 16'hffff, tp3);
         {clr1, clr3} = 2'b11;
         idle(1);
         {clr1, clr3} = 0;
         idle(1);
         chk("flags clear", 0, {f1, f3});
      end
      // channel m compares against vv[4 - m]: a at 0x86, b at 0x84, c at 0x82
      vv[2] = 16'h5aa5;
      for (int m = 0; m < 3; m++) begin
         c3 = vv[4 - m] + 16'h1;
         idle(1);
         mclr = 3'b111;
         idle(1);
         mclr = 0;
         idle(1);
         chk("match clear", 0, mf[m]);
         c3 = vv[4 - m];
         idle(3);
         chk("match set", 1, mf[m]);
      end
      end_of_test;
   end
endmodule : testbench

bind tcc_regs tcc_regs_sva chk_i (.mclk_i, .rstn_i, .bus_i, .rdata_o, .hit_o, .timer3_i,
   .timer3_rising_i, .timer1_capture_is_top_i, .timer3_capture_flag_clr_i,
   .first_timer_capture_value_o, .third_timer_capture_value_o, .third_timer_compare_b_o,
   .timer1_top_o, .third_timer_capture_flag_o, .third_timer_match_flag_o);
